// *** bench/adcsr_host.sv ***
// host serial port model: clocks out one frame and collects the bits
`timescale 1ns/1ps
`default_nettype none
module adcsr_host
(
    input wire logic clk_i, // core clock, request handshake
    input wire logic go_i, // start a read
    input wire logic [4:0] pulses_i, // serial clock pulses to give
    input wire logic serial_out_i, // serial data from the device
    input wire logic oe_n_i, // device data enable, low drives
    output logic sclk_o, // serial clock, still between frames
    output logic done_o, // one core cycle pulse, word valid
    output logic [15:0] word_o // first sixteen bits read
);
    logic line;
    logic last;
    // a released line shows the inverse of the last bit, never a stale copy
    assign line = oe_n_i ? ~last : serial_out_i;
    initial
    begin
        sclk_o = 1'b0;
        done_o = 1'b0;
        word_o = 16'h0000;
        last = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (go_i)
            begin
                #7;
                // clock low outside frames, so every start fall finds it low and resets the frame
                for (int k = 0; k < int'(pulses_i); k++)
                begin
                    #15 sclk_o = 1'b1;
                    #15;
                    if (k < 16)
                        word_o[15-k] = line;
                    last = line;
                    sclk_o = 1'b0;
                end
                @(posedge clk_i) done_o <= 1'b1;
                @(posedge clk_i) done_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/adcsr_top_checker.sv ***
// assertion checker for the converter control and serial readout
`timescale 1ns/1ps
`default_nettype none
module adcsr_top_checker
    import adcsr_pkg::*;
(
    input wire logic core_clk_i, // core clock
    input wire logic resetn_i, // reset, active low
    input wire logic ce_i, // clock enable
    input wire logic conversion_start_n_i, // start pin
    input wire logic [RESULT_W-1:0] sample_code_i, // quantiser code
    input wire logic serial_clk_i, // host serial clock
    input wire logic busy_o, // busy
    input wire logic hold_o, // hold
    input wire logic sleep_o, // sleep
    input wire logic serial_out_o, // serial data
    input wire logic serial_oe_n_o // data enable, low drives
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // hold only ever inside a busy period
    property p_hold_in_busy;
        hold_o |-> busy_o;
    endproperty
    a_hold_in_busy: assert property (p_hold_in_busy)
        else $error("hold without busy");

    // tracking resumes with the busy fall
    property p_track_at_end;
        $fell(busy_o) |-> $fell(hold_o);
    endproperty
    a_track_at_end: assert property (p_track_at_end)
        else $error("hold did not fall with busy");

    // hold spans the timer, the end edge and the push edge: 5 us with sync
    property p_conv_len;
        $rose(hold_o) |-> ##47 $fell(hold_o);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");

    // sync latency allowed for the pin
    property p_start_busy;
        $fell(conversion_start_n_i) && !busy_o && !sleep_o |-> ##[1:5] busy_o;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("busy did not follow start fall");

    property p_sleep_low;
        $fell(busy_o) && !conversion_start_n_i && !$past(conversion_start_n_i, 4) |-> sleep_o;
    endproperty
    a_sleep_low: assert property (p_sleep_low)
        else $error("no sleep with start low");

    property p_track_high;
        $fell(busy_o) && conversion_start_n_i && $past(conversion_start_n_i, 4) |-> !sleep_o;
    endproperty
    a_track_high: assert property (p_track_high)
        else $error("sleep with start high");

    property p_wake;
        $rose(conversion_start_n_i) && sleep_o |-> ##[48:52] $rose(hold_o);
    endproperty
    a_wake: assert property (p_wake)
        else $error("hold not at wake end");

    // frame reset needs the serial clock low at the fall
    property p_frame_reset;
        $fell(conversion_start_n_i) && !serial_clk_i && !$past(serial_clk_i, 2)
            |-> ##[1:5] serial_oe_n_o;
    endproperty
    a_frame_reset: assert property (p_frame_reset)
        else $error("frame not reset by start fall");

    property p_sleep_idle;
        sleep_o |-> !busy_o;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("sleep while busy");
endmodule

bind adcsr_top adcsr_top_checker u_chk (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .conversion_start_n_i(conversion_start_n_i),
    .sample_code_i(sample_code_i),
    .serial_clk_i(serial_clk_i),
    .busy_o(busy_o),
    .hold_o(hold_o),
    .sleep_o(sleep_o),
    .serial_out_o(serial_out_o),
    .serial_oe_n_o(serial_oe_n_o)
);
`default_nettype wire

// *** bench/adcsr_top_test.sv ***
// self-checking testbench of the converter control and serial readout
`timescale 1ns/1ps
`default_nettype none
module adcsr_top_test;
    import adcsr_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic conversion_start_n_i = 1'b1;
    logic [RESULT_W-1:0] sample_code_i = 14'h0000;
    logic busy_o, hold_o, sleep_o, serial_out_o, serial_oe_n_o;
    logic serial_clk, host_done;
    logic host_go = 1'b0;
    logic [4:0] host_pulses = 5'h10;
    logic [15:0] host_word;
    logic [31:0] seed = 32'h0000003b;
    logic [15:0] exp_q[$];
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #50 core_clk_i = ~core_clk_i;

    adcsr_top uut (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .ce_i(1'b1),
        .conversion_start_n_i(conversion_start_n_i),
        .sample_code_i(sample_code_i),
        .serial_clk_i(serial_clk),
        .busy_o(busy_o),
        .hold_o(hold_o),
        .sleep_o(sleep_o),
        .serial_out_o(serial_out_o),
        .serial_oe_n_o(serial_oe_n_o)
    );

    adcsr_host u_host (
        .clk_i(core_clk_i),
        .go_i(host_go),
        .pulses_i(host_pulses),
        .serial_out_i(serial_out_o),
        .oe_n_i(serial_oe_n_o),
        .sclk_o(serial_clk),
        .done_o(host_done),
        .word_o(host_word)
    );

    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
        num_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // bounded wait on busy or the host flag, looked at on the settled half
    task automatic wait_on(input bit on_done, input logic want, input int limit, input string what);
        logic seen;
        seen = ~want;
        for (int i = 0; i < limit && seen !== want; i++)
        begin
            @(negedge core_clk_i);
            seen = on_done ? host_done : busy_o;
        end
        // back onto the rising edge so later drives stay on it
        @(posedge core_clk_i);
        check({15'h0000, seen}, {15'h0000, want}, what);
    endtask

    // one conversion, then one read of the given pulse count
    task automatic conv(input logic stay_low, input logic [4:0] pulses);
        logic [13:0] c;
        seed = next_rnd(seed);
        c = seed[13:0];
        @(posedge core_clk_i);
        sample_code_i <= c;
        // quiet gap after the last read lets the track/hold settle
        repeat (4) @(posedge core_clk_i);
        if (conversion_start_n_i === 1'b0)
        begin
            conversion_start_n_i <= 1'b1;
            repeat (10) @(posedge core_clk_i);
        end
        conversion_start_n_i <= 1'b0;
        if (!stay_low)
        begin
            repeat (3) @(posedge core_clk_i);
            conversion_start_n_i <= 1'b1;
        end
        wait_on(1'b0, 1'b1, 10, "busy rise");
        wait_on(1'b0, 1'b0, 150, "busy fall");
        check({15'h0000, sleep_o}, {15'h0000, stay_low}, "mode");
        // bipolar coding: offset binary with the msb turned round
        exp_q.push_back({LEAD_ZEROS, ~c[13], c[12:0]});
        host_pulses <= pulses;
        host_go <= 1'b1;
        @(posedge core_clk_i);
        host_go <= 1'b0;
        wait_on(1'b1, 1'b1, 100, "read done");
        check({15'h0000, serial_oe_n_o}, {15'h0000, pulses == 5'h10}, "release");
    endtask

    // compare every finished read with the oldest expectation, mid-cycle
    always @(negedge core_clk_i)
        if (host_done === 1'b1)
            check(host_word, exp_q.pop_front(), "frame");

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            $display("ERROR %0t run did not finish", $time);
            end_sim();
        end
    end

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        check({12'h000, busy_o, hold_o, sleep_o, serial_oe_n_o}, 16'h0001, "idle");
        repeat (3) conv(1'b0, 5'h10);
        conv(1'b0, 5'h11);
        conv(1'b0, 5'h10);
        conv(1'b1, 5'h10);
        conv(1'b1, 5'h10);
        conv(1'b0, 5'h10);
        end_sim();
    end
endmodule
`default_nettype wire

// *** hw/adcsr_fifo.sv ***
// small result fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adcsr_fifo
    import adcsr_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)
(
    input wire logic clk_i,               // core clock
    input wire logic rst_n_i,             // synchronised reset, active low
    input wire logic ce_i,                // clock enable
    input wire logic in_valid_i,          // writer offers a word
    output logic in_ready_o,              // room for a word
    input wire logic [WIDTH-1:0] in_data_i, // word written
    output logic out_valid_o,             // a word is waiting
    input wire logic out_ready_i,         // reader takes the word
    output logic [WIDTH-1:0] out_data_o   // oldest word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_idx_reg;
    logic [AW-1:0] rd_idx_reg;
    logic [AW:0] fill_reg;
    wire push = in_valid_i && in_ready_o && ce_i;
    wire pop = out_valid_o && out_ready_i && ce_i;

    // honest flags straight from the fill count
    assign in_ready_o = (fill_reg != FULL_CNT);
    assign out_valid_o = (fill_reg != '0);
    assign out_data_o = mem_reg[rd_idx_reg];

    // storage needs no reset, only the pointers and the fill count do
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_reg[wr_idx_reg] <= in_data_i;
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            if (push)
                wr_idx_reg <= (wr_idx_reg == LAST_IDX) ? '0 : wr_idx_reg + 1'b1;
            if (pop)
                rd_idx_reg <= (rd_idx_reg == LAST_IDX) ? '0 : rd_idx_reg + 1'b1;
            if (push && !pop)
                fill_reg <= fill_reg + 1'b1;
            else if (pop && !push)
                fill_reg <= fill_reg - 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** hw/adcsr_top.sv ***
// conversion control and serial readout of a 14-bit successive-approximation converter
// Function
// - falling conversion start in high sampling mode starts conversion and enters hold
// - busy rises on conversion start fall, falls at conversion end within 5 us
// - finished result is loaded into the output register for the next read
// - track/hold returns to tracking when busy falls
// - auto-sleep: rising start edge wakes, hold begins 5 us later if the start pin fell during the wake, else back to tracking
// - a read is 16 pulses; afterwards shift register sits at its end and output floats until a further pulse
// - pulses beyond the sixteenth move the shift register on past reset
// - a conversion start fall while the serial clock is low resets the output shift register
// - bipolar variant presents twos complement, one step is full scale over 16384
// - unipolar variant presents straight binary, one step is full scale over 16384
// - start level at conversion end picks high sampling or auto-sleep
// - frame is two zeros then 14 result bits msb first, falling edges
`timescale 1ns/1ps
`default_nettype none
module adcsr_top
    import adcsr_pkg::*;
#(
    parameter bit BIPOLAR = CODE_BIPOLAR
)
(
    input wire logic core_clk_i,                  // 10 MHz conversion clock
    input wire logic resetn_i,                    // asynchronous reset, active low
    input wire logic ce_i,                        // clock enable of the core domain
    input wire logic conversion_start_n_i,        // conversion start pin, active low
    input wire logic [RESULT_W-1:0] sample_code_i, // quantiser code, 0 at negative full scale
    input wire logic serial_clk_i,                // host serial clock
    output logic busy_o,                          // conversion in progress
    output logic hold_o,                          // track/hold in hold
    output logic sleep_o,                         // auto-sleep power-down
    output logic serial_out_o,                    // serial data
    output logic serial_oe_n_o                    // serial data enable, low drives
);

    // reset release through two flip-flops
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // pins and the link level enter the core domain through two flip-flops
    logic [2:0] sync_meta_reg;
    logic [2:0] sync_reg;
    logic conv_n_dly_reg;
    logic read_live;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            sync_meta_reg <= 3'h7;
            sync_reg <= 3'h7;
            conv_n_dly_reg <= 1'b1;
        end
        else if (ce_i)
        begin
            sync_meta_reg <= {read_live, serial_clk_i, conversion_start_n_i};
            sync_reg <= sync_meta_reg;
            conv_n_dly_reg <= sync_reg[0];
        end
    end

    // edge and level decode of the synchronised pins
    wire conv_n_lvl = sync_reg[0];
    wire sclk_lvl = sync_reg[1];
    wire read_busy = sync_reg[2];
    wire conv_fall = conv_n_dly_reg && !conv_n_lvl;
    wire conv_rise = !conv_n_dly_reg && conv_n_lvl;

    // output coding: twos complement flips the msb of the offset code
    function automatic logic [RESULT_W-1:0] code_map(input logic [RESULT_W-1:0] raw);
        logic [RESULT_W-1:0] res;
        res = raw;
        if (BIPOLAR)
            res[RESULT_MSB] = ~raw[RESULT_MSB];
        return res;
    endfunction

    // control state
    adcsr_state_t state_reg;
    adcsr_state_t state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic [RESULT_W-1:0] code_reg;
    logic busy_reg;
    logic busy_next;
    logic hold_reg;
    logic hold_next;
    logic sleep_reg;
    logic sleep_next;
    logic pend_reg;
    logic pend_next;
    logic sample_now;
    logic push_req;
    logic fifo_in_ready;
    logic link_clr_reg;

    wire tmr_done = (tmr_reg == TMR_ZERO);
    // a full buffer refuses new conversions instead of losing a result
    wire start_ok = conv_fall && fifo_in_ready;

    // next-state logic of the converter
    always_comb
    begin
        state_next = state_reg;
        tmr_next = tmr_done ? tmr_reg : tmr_reg - 1'b1;
        busy_next = busy_reg;
        hold_next = hold_reg;
        sleep_next = sleep_reg;
        pend_next = pend_reg;
        sample_now = 1'b0;
        push_req = 1'b0;
        case (state_reg)
            ADCSR_TRACK:
            begin
                if (start_ok)
                begin
                    state_next = ADCSR_CONV;
                    tmr_next = CONV_CNT;
                    busy_next = 1'b1;
                    hold_next = 1'b1;
                    sample_now = 1'b1;
                end
            end
            ADCSR_CONV:
            begin
                if (tmr_done)
                    state_next = ADCSR_PUSH;
            end
            ADCSR_PUSH:
            begin
                push_req = 1'b1;
                if (fifo_in_ready)
                begin
                    busy_next = 1'b0;
                    hold_next = 1'b0;
                    pend_next = 1'b0;
                    if (conv_n_lvl)
                        state_next = ADCSR_TRACK;
                    else
                    begin
                        state_next = ADCSR_SLEEP;
                        sleep_next = 1'b1;
                    end
                end
            end
            ADCSR_SLEEP:
            begin
                if (conv_rise)
                begin
                    state_next = ADCSR_WAKE;
                    tmr_next = WAKE_CNT;
                    sleep_next = 1'b0;
                end
            end
            ADCSR_WAKE:
            begin
                // a short start pulse is remembered; hold waits for the wake time
                if (start_ok)
                begin
                    pend_next = 1'b1;
                    busy_next = 1'b1;
                end
                if (tmr_done)
                begin
                    if (pend_reg || start_ok)
                    begin
                        state_next = ADCSR_CONV;
                        tmr_next = CONV_CNT;
                        busy_next = 1'b1;
                        hold_next = 1'b1;
                        sample_now = 1'b1;
                    end
                    else
                        state_next = ADCSR_TRACK;
                end
            end
            default:
            begin
                state_next = ADCSR_TRACK;
            end
        endcase
    end

    // control registers
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= ADCSR_TRACK;
            tmr_reg <= TMR_ZERO;
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
            sleep_reg <= 1'b0;
            pend_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            busy_reg <= busy_next;
            hold_reg <= hold_next;
            sleep_reg <= sleep_next;
            pend_reg <= pend_next;
        end
    end

    // sample the quantiser code at the hold instant
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            code_reg <= RESULT_RST;
        else if (ce_i && sample_now)
            code_reg <= code_map(sample_code_i);
    end

    // link clear pulse only while the serial clock sits low
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            link_clr_reg <= 1'b1;
        else if (ce_i)
            link_clr_reg <= conv_fall && !sclk_lvl;
    end

    // result buffer between conversion and output register
    logic fifo_out_valid;
    logic [RESULT_W-1:0] fifo_out_data;
    // the output register is not touched while a frame is being shifted out
    wire drain_ready = !read_busy;

    adcsr_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_reg),
        .ce_i(ce_i),
        .in_valid_i(push_req),
        .in_ready_o(fifo_in_ready),
        .in_data_i(code_reg),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(drain_ready),
        .out_data_o(fifo_out_data)
    );

    // output register holding the frame that the link shifts out
    adcsr_frame_t frame_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            frame_reg.lead <= LEAD_ZEROS;
            frame_reg.code <= RESULT_RST;
        end
        else if (ce_i && fifo_out_valid && drain_ready)
        begin
            frame_reg.lead <= LEAD_ZEROS;
            frame_reg.code <= fifo_out_data;
        end
    end

    // link domain: cleared by reset or by the start-edge pulse, since the
    // serial clock is stopped when the clear must act
    wire link_rst_n = rst_n_reg && !link_clr_reg;
    logic [BITCNT_W-1:0] bit_cnt_reg;
    logic started_reg;

    // falling serial edges step the bit counter; it runs on past the end
    always_ff @(negedge serial_clk_i or negedge link_rst_n)
    begin
        if (!link_rst_n)
            bit_cnt_reg <= BITCNT_RST;
        else
            bit_cnt_reg <= bit_cnt_reg + BITCNT_ONE;
    end

    // first rising edge opens the data output
    always_ff @(posedge serial_clk_i or negedge link_rst_n)
    begin
        if (!link_rst_n)
            started_reg <= 1'b0;
        else
            started_reg <= 1'b1;
    end

    // bit select: index wraps every 16 so extra pulses replay the frame
    wire frame_end = (bit_cnt_reg == BITCNT_END);
    wire [3:0] bit_idx = 4'hf - bit_cnt_reg[3:0];
    wire [FRAME_BITS-1:0] frame_bits = frame_reg;
    assign read_live = started_reg && !frame_end;

    // outputs
    assign busy_o = busy_reg;
    assign hold_o = hold_reg;
    assign sleep_o = sleep_reg;
    assign serial_out_o = frame_bits[bit_idx];
    assign serial_oe_n_o = !started_reg || frame_end;

endmodule
`default_nettype wire

// *** shared/adcsr_pkg.sv ***
// shared constants and carrier types of the converter control and serial readout
package adcsr_pkg;

    // core clock and conversion timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 5000;
    localparam int WAKE_TIME_NS = 5000;
    localparam int SYNC_LAT_CYC = 3;
    // leaving a timed state costs edges of its own: end and push, or wake exit
    localparam int CONV_EXIT_CYC = 2;
    localparam int WAKE_EXIT_CYC = 1;
    // longest times round down; sync latency and exit edges come off both timers
    localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS - SYNC_LAT_CYC - CONV_EXIT_CYC;
    localparam int WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS - SYNC_LAT_CYC - WAKE_EXIT_CYC;
    localparam int TMR_W = 6;
    localparam logic [TMR_W-1:0] CONV_CNT = TMR_W'(CONV_CYC);
    localparam logic [TMR_W-1:0] WAKE_CNT = TMR_W'(WAKE_CYC);
    localparam logic [TMR_W-1:0] TMR_ZERO = 6'h00;

    // result and serial frame layout
    localparam int RESULT_W = 14;
    localparam int FRAME_BITS = 16;
    localparam int LEAD_W = FRAME_BITS - RESULT_W;
    localparam int RESULT_MSB = RESULT_W - 1;
    localparam logic [LEAD_W-1:0] LEAD_ZEROS = 2'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 5'h00;
    localparam logic [BITCNT_W-1:0] BITCNT_END = 5'h10;
    localparam logic [BITCNT_W-1:0] BITCNT_ONE = 5'h01;

    // result buffer
    localparam int FIFO_DEPTH = 8;

    // output coding selection
    localparam bit CODE_BIPOLAR = 1'b1;
    localparam bit CODE_UNIPOLAR = 1'b0;

    // control states of the converter
    typedef enum logic [2:0] {
        ADCSR_TRACK,
        ADCSR_CONV,
        ADCSR_PUSH,
        ADCSR_SLEEP,
        ADCSR_WAKE
    } adcsr_state_t;

    // one serial frame: leading zeros, then the result msb first
    typedef struct packed {
        logic [LEAD_W-1:0] lead;
        logic [RESULT_W-1:0] code;
    } adcsr_frame_t;

endpackage
